// ==== design/swire_pkg.sv ====
// constants, state type and time figures for the single-wire bus timing engine
package swire_pkg;

  // ==========================================================================
  // clock and timebase
  localparam int unsigned CLK_NS     = 10;
  localparam int unsigned TICK_US_NS = 1000;
  localparam int unsigned TICK_OD_NS = 50;
  localparam logic [7:0]  DIV_US_RST = 8'(TICK_US_NS / CLK_NS);
  localparam logic [7:0]  DIV_OD_RST = 8'(TICK_OD_NS / CLK_NS);
  localparam int          EL_W       = 16;

  // ==========================================================================
  // speed codes
  localparam logic [1:0] SPD_STD  = 2'h0;
  localparam logic [1:0] SPD_OD   = 2'h1;
  localparam logic [1:0] SPD_LONG = 2'h2;

  // ==========================================================================
  // register map and fields
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CFG  = 8'h04;
  localparam int CTL_RESET     = 0;
  localparam int CTL_SLOT      = 1;
  localparam int CTL_BIT       = 2;
  localparam int CTL_READ      = 3;
  localparam int CTL_FIRST     = 4;
  localparam int CTL_LAST      = 5;
  localparam int CFG_SPD_LSB   = 0;
  localparam int CFG_MASK      = 2;
  localparam int CFG_SPU_EN    = 3;
  localparam int CFG_SPU_HOLD  = 4;
  localparam int CFG_DIVUS_LSB = 8;
  localparam int CFG_DIVOD_LSB = 16;
  localparam logic [31:0] CFG_RST = {8'h00, DIV_OD_RST, DIV_US_RST, 8'h08};

  typedef enum logic [2:0] {S_IDLE, S_OFF, S_RLOW, S_RHIGH, S_SLOT} state_e;

  // ==========================================================================
  // time figures in ns, indexed standard, overdrive, long line
  typedef int unsigned span_t [3];
  localparam span_t RST_LOW_NS  = '{500800, 50400, 500800};
  localparam span_t RST_HIGH_NS = '{508800, 59200, 508800};
  localparam span_t PDS_NS      = '{24000, 2400, 30400};
  localparam span_t PDHCNT_NS   = '{60000, 6400, 60000};
  localparam span_t SLOT_NS     = '{68800, 12000, 68800};
  localparam span_t LOW1_NS     = '{4800, 800, 7200};
  localparam span_t LOW0_NS     = '{62400, 8000, 62400};
  localparam span_t RDV_NS      = '{12000, 1600, 20000};
  localparam span_t ON1_NS      = '{6400, 800, 6400};
  localparam span_t ON2_NS      = '{8000, 8000, 8000};
  localparam span_t ON3_NS      = '{51200, 7200, 51200};
  localparam span_t ON4_NS      = '{6400, 800, 6400};
  localparam span_t DLY1_NS     = '{800, 800, 800};
  localparam span_t DLY2_NS     = '{399200, 31200, 399200};
  localparam span_t DLY3_NS     = '{800, 800, 800};
  localparam span_t OFF1_NS     = '{1600, 1600, 1600};
  localparam span_t OFF2_NS     = '{800, 800, 800};
  localparam span_t OFFF_NS     = '{4000, 4000, 4000};
  localparam span_t MASK_NS     = '{15000, 15000, 15000};

  // least time rounded up to whole ticks of the selected timebase
  function automatic logic [EL_W-1:0] spanTicks(span_t span, logic [1:0] spd);
    int unsigned t;
    int unsigned idx;
    t   = (spd == SPD_OD) ? TICK_OD_NS : TICK_US_NS;
    idx = (spd == SPD_OD) ? 1 : ((spd == SPD_LONG) ? 2 : 0);
    return EL_W'((span[idx] + t - 1) / t);
  endfunction

endpackage

// ==== design/swire_time_if.sv ====
// timebase carrier between the engine, its divider and its elapsed counter
interface swire_time_if;
  logic                       restart;
  logic [7:0]                 divisor;
  logic                       tick;
  logic [swire_pkg::EL_W-1:0] elapsed;

  modport gen  (input restart, input divisor, output tick);
  modport cnt  (input restart, input tick, output elapsed);
  modport user (output restart, output divisor, input tick, input elapsed);
endinterface

// ==== design/swire_tick_gen.sv ====
// divider that makes the state-machine timebase tick from the system clock
module swire_tick_gen (
  // system
  input  wire logic clk,
  input  wire logic nrst,
  // timebase
  swire_time_if.gen tb
);

  logic [7:0] cnt_q;
  logic       tick_q;
  logic       last;

  assign last    = (tb.divisor <= 8'h01) || (cnt_q >= tb.divisor - 8'h01);
  assign tb.tick = tick_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= (tb.restart || last) ? 8'h00 : cnt_q + 8'h01;
      tick_q <= !tb.restart && last;
    end
  end

endmodule // swire_tick_gen

// ==== design/swire_elapsed.sv ====
// counts timebase ticks since the engine last entered a state
module swire_elapsed (
  // system
  input  wire logic clk,
  input  wire logic nrst,
  // timebase
  swire_time_if.cnt tb
);

  logic [swire_pkg::EL_W-1:0] el_q;

  assign tb.elapsed = el_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      el_q <= '0;
    else if (tb.restart)
      el_q <= '0;
    else if (tb.tick && (el_q != '1))
      el_q <= el_q + 1'b1;
  end

endmodule // swire_elapsed

// ==== design/swire_master.sv ====
// single-wire bus master timing engine with a wishbone register slave
//
// Added by the designer: the Wishbone slave port and the register addresses.

module swire_master (
  // system
  input  wire logic        clk,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output      logic [31:0] dat_o,
  output      logic        ack_o,
  // open-drain bus line
  input  wire logic        busLineIn,
  output      logic        busLineOut,
  output      logic        busLineOeN,
  // strong pull-up, active low
  output      logic        strongPullupEnableN
);

  // ==========================================================================
  // declarations
  swire_pkg::state_e          state_q;
  swire_pkg::state_e          stateD;
  logic                       ack_q;
  logic [31:0]                dat_q;
  logic [7:0]                 cfgByte_q [4];
  logic [31:0]                cfg;
  logic [1:0]                 spd;
  logic                       presenceMask;
  logic                       spuEn;
  logic                       isReset_q;
  logic                       bitVal_q;
  logic                       isRead_q;
  logic                       first_q;
  logic                       last_q;
  logic                       presence_q;
  logic                       lowSeen_q;
  logic                       readBit_q;
  logic [swire_pkg::EL_W-1:0] spuLeft_q;
  logic                       spuRec_q;
  logic                       spuHold_q;
  logic                       lineOeN_q;
  logic                       lineOut_q;
  logic                       spuN_q;
  logic                       acc;
  logic                       cmdGo;
  logic                       driveLow;
  logic                       spuOn;
  logic                       slotRecGo;
  logic                       rstRecGo;
  logic [31:0]                rdData;
  logic [swire_pkg::EL_W-1:0] el;
  logic [swire_pkg::EL_W-1:0] rstLowT, rstHighT, pdsT, pdhT, slotT, lowT, rdvT;
  logic [swire_pkg::EL_W-1:0] on1T, on2T, onBitT, dly1T, dly2T, dly3T, offT, maskT;

  swire_time_if tm ();

  // ==========================================================================
  // timebase
  swire_tick_gen u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tb   (tm.gen)
  );

  swire_elapsed u_elapsed (
    .clk  (clk),
    .nrst (nrst),
    .tb   (tm.cnt)
  );

  assign el         = tm.elapsed;
  assign tm.restart = (stateD != state_q);
  // overdrive runs on the fine tick, the other speeds on the microsecond tick
  assign tm.divisor = (spd == swire_pkg::SPD_OD) ? cfg[swire_pkg::CFG_DIVOD_LSB +: 8]
                                                 : cfg[swire_pkg::CFG_DIVUS_LSB +: 8];

  // true on the tick that brings the elapsed count up to x
  function automatic logic reach(logic [swire_pkg::EL_W-1:0] x);
    return tm.tick && (el == x - 1'b1);
  endfunction

  // ==========================================================================
  // configuration and interval selection
  assign cfg   = {cfgByte_q[3], cfgByte_q[2], cfgByte_q[1], cfgByte_q[0]};
  assign spd   = (cfg[swire_pkg::CFG_SPD_LSB +: 2] == 2'h3) ? swire_pkg::SPD_STD
                                                            : cfg[swire_pkg::CFG_SPD_LSB +: 2];
  assign presenceMask = cfg[swire_pkg::CFG_MASK];
  assign spuEn = cfg[swire_pkg::CFG_SPU_EN];

  always_comb
  begin
    rstLowT  = swire_pkg::spanTicks(swire_pkg::RST_LOW_NS, spd);
    rstHighT = swire_pkg::spanTicks(swire_pkg::RST_HIGH_NS, spd);
    pdsT     = swire_pkg::spanTicks(swire_pkg::PDS_NS, spd);
    pdhT     = swire_pkg::spanTicks(swire_pkg::PDHCNT_NS, spd);
    slotT    = swire_pkg::spanTicks(swire_pkg::SLOT_NS, spd);
    rdvT     = swire_pkg::spanTicks(swire_pkg::RDV_NS, spd);
    on1T     = swire_pkg::spanTicks(swire_pkg::ON1_NS, spd);
    on2T     = swire_pkg::spanTicks(swire_pkg::ON2_NS, spd);
    dly1T    = swire_pkg::spanTicks(swire_pkg::DLY1_NS, spd);
    dly2T    = swire_pkg::spanTicks(swire_pkg::DLY2_NS, spd);
    dly3T    = swire_pkg::spanTicks(swire_pkg::DLY3_NS, spd);
    maskT    = swire_pkg::spanTicks(swire_pkg::MASK_NS, spd);
    // a read slot opens like a write one
    lowT     = (bitVal_q || isRead_q) ? swire_pkg::spanTicks(swire_pkg::LOW1_NS, spd)
                                      : swire_pkg::spanTicks(swire_pkg::LOW0_NS, spd);
    onBitT   = (bitVal_q || isRead_q) ? swire_pkg::spanTicks(swire_pkg::ON3_NS, spd)
                                      : swire_pkg::spanTicks(swire_pkg::ON4_NS, spd);
    if (isReset_q)
      offT = swire_pkg::spanTicks(swire_pkg::OFF1_NS, spd);
    else if (first_q)
      offT = swire_pkg::spanTicks(swire_pkg::OFFF_NS, spd);
    else
      offT = swire_pkg::spanTicks(swire_pkg::OFF2_NS, spd);
  end

  // ==========================================================================
  // wishbone slave: one wait state, ack for one cycle
  assign acc   = cyc_i && stb_i && !ack_q;
  assign cmdGo = acc && we_i && (adr_i == swire_pkg::ADR_CTRL) && sel_i[0] && (state_q == swire_pkg::S_IDLE)
                 && (dat_i[swire_pkg::CTL_RESET] || dat_i[swire_pkg::CTL_SLOT]);
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_comb
  begin
    if (adr_i == swire_pkg::ADR_CTRL)
      rdData = {27'h0, spuOn, busLineIn, readBit_q, presence_q, state_q != swire_pkg::S_IDLE};
    else if (adr_i == swire_pkg::ADR_CFG)
      rdData = cfg;
    else
      rdData = 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc;
      if (acc && !we_i)
        dat_q <= rdData;
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_cfg
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        cfgByte_q[i] <= swire_pkg::CFG_RST[8*i +: 8];
      else if (acc && we_i && sel_i[i] && (adr_i == swire_pkg::ADR_CFG))
        cfgByte_q[i] <= dat_i[8*i +: 8];
    end
  end

  // ==========================================================================
  // command capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      isReset_q <= 1'b0;
      bitVal_q  <= 1'b0;
      isRead_q  <= 1'b0;
      first_q   <= 1'b0;
      last_q    <= 1'b0;
    end
    else if (cmdGo)
    begin
      isReset_q <= dat_i[swire_pkg::CTL_RESET];
      bitVal_q  <= dat_i[swire_pkg::CTL_BIT];
      isRead_q  <= dat_i[swire_pkg::CTL_READ];
      first_q   <= dat_i[swire_pkg::CTL_FIRST];
      last_q    <= dat_i[swire_pkg::CTL_LAST];
    end
  end

  // ==========================================================================
  // sequencer
  always_comb
  begin
    stateD = state_q;
    case (state_q)
      swire_pkg::S_IDLE:  if (cmdGo) stateD = swire_pkg::S_OFF;
      swire_pkg::S_OFF:   if (el >= offT) stateD = isReset_q ? swire_pkg::S_RLOW : swire_pkg::S_SLOT;
      swire_pkg::S_RLOW:  if (el >= rstLowT) stateD = swire_pkg::S_RHIGH;
      swire_pkg::S_RHIGH: if (el >= rstHighT) stateD = swire_pkg::S_IDLE;
      swire_pkg::S_SLOT:  if (el >= slotT) stateD = swire_pkg::S_IDLE;
      default:            stateD = swire_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= swire_pkg::S_IDLE;
    else
      state_q <= stateD;
  end

  // ==========================================================================
  // line drive
  always_comb
  begin
    driveLow = 1'b0;
    if (state_q == swire_pkg::S_RLOW)
      driveLow = 1'b1;
    else if (state_q == swire_pkg::S_RHIGH)
      driveLow = presenceMask && (spd == swire_pkg::SPD_STD) && (el >= maskT);
    else if (state_q == swire_pkg::S_SLOT)
      driveLow = (el < lowT);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lineOeN_q <= 1'b1;
      lineOut_q <= 1'b0;
    end
    else
    begin
      lineOeN_q <= !driveLow;
      lineOut_q <= 1'b0;
    end
  end

  assign busLineOeN = lineOeN_q;
  assign busLineOut = lineOut_q;

  // ==========================================================================
  // presence detect and read capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      presence_q <= 1'b0;
      lowSeen_q  <= 1'b0;
      readBit_q  <= 1'b0;
    end
    else if (cmdGo && dat_i[swire_pkg::CTL_RESET])
    begin
      presence_q <= 1'b0;
      lowSeen_q  <= 1'b0;
    end
    else if (state_q == swire_pkg::S_RHIGH)
    begin
      if (!busLineIn)
        lowSeen_q <= 1'b1;
      if (reach(pdsT))
        presence_q <= !busLineIn;
      else if (reach(pdhT))
        presence_q <= presence_q && lowSeen_q;
    end
    else if ((state_q == swire_pkg::S_SLOT) && isRead_q && reach(rdvT))
      readBit_q <= busLineIn;
  end

  // ==========================================================================
  // strong pull-up
  assign rstRecGo  = (state_q == swire_pkg::S_RHIGH) && !spuRec_q && tm.tick && busLineIn
                     && (el >= dly2T);
  assign slotRecGo = (state_q == swire_pkg::S_SLOT) && !spuRec_q && tm.tick && busLineIn
                     && (el >= 16'(lowT + dly3T));
  assign spuOn     = spuEn && (state_q != swire_pkg::S_OFF) && ((spuLeft_q != '0) || spuHold_q);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      spuLeft_q <= '0;
      spuRec_q  <= 1'b0;
      spuHold_q <= 1'b0;
      spuN_q    <= 1'b1;
    end
    else
    begin
      spuN_q <= !spuOn;
      if (state_q == swire_pkg::S_OFF)
      begin
        spuLeft_q <= '0;
        spuHold_q <= 1'b0;
      end
      else if ((state_q == swire_pkg::S_RHIGH) && reach(dly1T))
        spuLeft_q <= on1T;
      else if (rstRecGo)
        spuLeft_q <= on2T;
      else if (slotRecGo)
        spuLeft_q <= onBitT;
      else if (tm.tick && (spuLeft_q != '0))
        spuLeft_q <= spuLeft_q - 1'b1;
      if (tm.restart)
        spuRec_q <= 1'b0;
      else if (rstRecGo || slotRecGo)
        spuRec_q <= 1'b1;
      if ((state_q == swire_pkg::S_SLOT) && (stateD == swire_pkg::S_IDLE) && last_q && cfg[swire_pkg::CFG_SPU_HOLD])
        spuHold_q <= 1'b1;
    end
  end

  assign strongPullupEnableN = spuN_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence rstCmdS;
    (state_q == swire_pkg::S_IDLE) ##0 cmdGo ##0 dat_i[swire_pkg::CTL_RESET];
  endsequence

  sequence offDoneS;
    (state_q == swire_pkg::S_OFF) ##0 (stateD != swire_pkg::S_OFF);
  endsequence

  rst_cmd_off_a: assert property (rstCmdS |=> (state_q == swire_pkg::S_OFF) ##0 isReset_q)
    else $error("reset command did not start the turn-off phase");
  off_len_a: assert property (offDoneS |-> (el == offT) && strongPullupEnableN)
    else $error("turn-off phase left early");
  rst_low_drive_a: assert property ((state_q == swire_pkg::S_RLOW) |=> !busLineOeN)
    else $error("line not driven low during reset pulse");
  rst_low_len_a: assert property ((state_q == swire_pkg::S_RLOW) && (stateD != swire_pkg::S_RLOW)
                                  |-> (el == rstLowT) && (stateD == swire_pkg::S_RHIGH))
    else $error("reset pulse length wrong");
  rst_high_len_a: assert property ((state_q == swire_pkg::S_RHIGH) && (stateD != swire_pkg::S_RHIGH)
                                   |-> el == rstHighT)
    else $error("reset release time wrong");
  rst_high_free_a: assert property ((state_q == swire_pkg::S_RHIGH) && !presenceMask |=> busLineOeN)
    else $error("line driven during reset release");
  mask_pull_a: assert property ((state_q == swire_pkg::S_RHIGH) && presenceMask && (spd == swire_pkg::SPD_STD)
                                && (el >= maskT) |=> !busLineOeN)
    else $error("presence masking did not pull the line low");
  pres_sample_a: assert property ((state_q == swire_pkg::S_RHIGH) && reach(pdsT)
                                  |=> presence_q == !$past(busLineIn))
    else $error("presence not sampled at its time");
  slot_low_a: assert property ((state_q == swire_pkg::S_SLOT) && (el < lowT) |=> !busLineOeN)
    else $error("slot low time not driven");
  slot_len_a: assert property ((state_q == swire_pkg::S_SLOT) && (stateD != swire_pkg::S_SLOT)
                               |-> el == slotT)
    else $error("slot length wrong");
  spu_high_a: assert property (slotRecGo |-> busLineIn ##1 (spuLeft_q == onBitT))
    else $error("pull-up recovery started on a low line");
  spu_off_a: assert property ((state_q == swire_pkg::S_OFF) |=> strongPullupEnableN)
    else $error("strong pull-up on during turn-off");

endmodule // swire_master

// ==== bench/swire_slave_model.sv ====
// slave device model on the single-wire bus: presence answer and read-zero hold
module swire_slave_model #(
  parameter int RST_MIN = 400,
  parameter int PD_WAIT = 30,
  parameter int PD_LOW  = 120,
  parameter int RD_HOLD = 40
) (
  // system
  input  wire logic clk,
  input  wire logic nrst,
  // bus
  input  wire logic busLine,
  input  wire logic present,
  input  wire logic sendZero,
  output      logic pullN
);
  timeunit 1ns;
  timeprecision 1ps;
  int   lowCnt;
  int   waitCnt;
  int   holdCnt;
  logic lineQ;

  // ==========================================================================
  // answer logic, counted in system clocks
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lowCnt  <= 0;
      waitCnt <= 0;
      holdCnt <= 0;
      lineQ   <= 1'b1;
    end
    else
    begin
      lineQ  <= busLine;
      lowCnt <= busLine ? 0 : lowCnt + 1;
      if (busLine && !lineQ && lowCnt > RST_MIN && present)
        waitCnt <= PD_WAIT;
      else if (waitCnt > 0)
        waitCnt <= waitCnt - 1;
      if (waitCnt == 1)
        holdCnt <= PD_LOW;
      else if (!busLine && lineQ && sendZero && holdCnt == 0)
        holdCnt <= RD_HOLD;
      else if (holdCnt > 0)
        holdCnt <= holdCnt - 1;
    end
  end

  assign pullN = (holdCnt == 0);
endmodule  // swire_slave_model

// ==== bench/single_wire_bus_master_timing_tb.sv ====
// self-checking bench for the single-wire bus master timing engine
module single_wire_bus_master_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, cycI, stbI, weI, ack, lineOut, lineOeN, spuN;
  logic        present, sendZero, pullN, busLine;
  logic [7:0]  adrI;
  logic [31:0] datI, datO, q;
  int          errTotal, nChecks, cycles, n, t;
  int          dv[3] = '{2, 1, 2};
  int          lowOne[3] = '{5, 16, 8};
  int          lowZero[3] = '{63, 160, 63};
  int          slotT[3] = '{69, 240, 69};
  logic [3:0]  selI;

  assign busLine = (lineOeN | lineOut) & pullN;

  swire_master swire_master_i (.clk(clk), .nrst(nrst), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
    .dat_i(datI), .sel_i(selI), .dat_o(datO), .ack_o(ack), .busLineIn(busLine), .busLineOut(lineOut),
    .busLineOeN(lineOeN), .strongPullupEnableN(spuN));
  swire_slave_model swire_slave_model_i (.clk(clk), .nrst(nrst), .busLine(busLine), .present(present),
    .sendZero(sendZero), .pullN(pullN));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cycles <= cycles + 1;

  // ==========================================================================
  // report and compare helpers
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic near(input string what, input int exp, input int got, input int slack);
    nChecks++;
    if (got < exp || got > exp + slack)
    begin
      errTotal++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    errTotal++;
    $display("ERROR %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  // ==========================================================================
  // wishbone classic access and line measurement
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI  <= w;
    adrI <= a;
    datI <= d;
    selI <= 4'hf;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50)
      hang("ack");
    r = datO;
    cycI <= 1'b0;
    stbI <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pollIdle;
    int k;
    k = 0;
    do
    begin
      wb(1'b0, swire_pkg::ADR_CTRL, 32'h0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 3000);
    if (k >= 3000)
      hang("busy");
  endtask

  // length in clocks of the next run at level lvl, on the line or on the pull-up enable
  task automatic span(input logic useSpu, input logic lvl, output int m);
    int k;
    k = 0;
    while ((useSpu ? spuN : busLine) !== lvl && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    m = 0;
    while ((useSpu ? spuN : busLine) === lvl && m < 20000)
    begin
      @(posedge clk);
      m++;
    end
    if (k >= 20000 || m >= 20000)
      hang("line");
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {nrst, cycI, stbI, weI, present, sendZero} = '0;
    adrI = 8'h00;
    datI = 32'h0;
    selI = 4'h0;
    errTotal = 0;
    nChecks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, swire_pkg::ADR_CFG, 32'h0, q);
    check("cfg reset", swire_pkg::CFG_RST, q);
    wb(1'b0, 8'h08, 32'h0, q);
    check("unmapped", 32'h0, q);
    wb(1'b1, swire_pkg::ADR_CFG, 32'h0001_0208, q);
    wb(1'b0, swire_pkg::ADR_CFG, 32'h0, q);
    check("cfg readback", 32'h0001_0208, q);
    for (int p = 0; p < 2; p++)
    begin
      present <= p[0];
      wb(1'b1, swire_pkg::ADR_CTRL, 32'h1, q);
      span(1'b0, 1'b0, n);
      near("reset low", 1002, n, 5);
      t = cycles;
      pollIdle();
      near("release", 1018, cycles - t, 12);
      check("presence", {31'h0, p[0]}, {31'h0, q[1]});
    end
    present <= 1'b0;
    for (int s = 0; s < 3; s++)
      for (int b = 0; b < 2; b++)
      begin
        wb(1'b1, swire_pkg::ADR_CFG, 32'h0001_0208 | s, q);
        wb(1'b1, swire_pkg::ADR_CTRL, 32'h2 | (b << 2), q);
        span(1'b0, 1'b0, n);
        t = cycles - n;
        near("bit low", (b ? lowOne[s] : lowZero[s]) * dv[s], n, dv[s] + 3);
        // pull-up recovery may outlast the slot, so at standard speed both are watched at once
        fork
          if (s == 0)
            span(1'b1, 1'b0, n);
          begin
            pollIdle();
            t = cycles - t;
          end
        join
        if (s == 0)
          near("pullup", b ? 104 : 14, n, 5);
        near("slot", slotT[s] * dv[s], t, 12);
      end
    // last bit with hold, then a first bit of the next byte
    wb(1'b1, swire_pkg::ADR_CFG, 32'h0001_0218, q);
    wb(1'b1, swire_pkg::ADR_CTRL, 32'h26, q);
    pollIdle();
    check("hold status", 32'h1, {31'h0, q[4]});
    repeat (200) @(posedge clk);
    check("hold pin", 32'h0, {31'h0, spuN});
    wb(1'b1, swire_pkg::ADR_CTRL, 32'h12, q);
    t = cycles;
    span(1'b0, 1'b0, n);
    near("first turn-off", 8, cycles - n - t, 3);
    pollIdle();
    wb(1'b1, swire_pkg::ADR_CFG, 32'h0001_0208, q);
    for (int z = 0; z < 2; z++)
    begin
      sendZero <= z[0];
      wb(1'b1, swire_pkg::ADR_CTRL, 32'ha, q);
      pollIdle();
      check("read bit", {31'h0, ~z[0]}, {31'h0, q[2]});
    end
    sendZero <= 1'b0;
    wb(1'b1, swire_pkg::ADR_CFG, 32'h0001_020c, q);
    wb(1'b1, swire_pkg::ADR_CTRL, 32'h1, q);
    span(1'b0, 1'b0, n);
    span(1'b0, 1'b1, n);
    near("mask release", 30, n, 4);
    pollIdle();
    tally_and_finish();
  end
endmodule  // single_wire_bus_master_timing_tb
